// ===== common/emb_defines.svh
// Constants for the external memory bus block: register offsets,
// field positions, reset values and machine cycle timing.
// Assumes inclusion by bare name from the design and its package users.
`ifndef EMB_DEFINES_SVH
`define EMB_DEFINES_SVH
// ----------------------------------------
// Register offsets on the register port
// ----------------------------------------
`define EMB_AUX_SEL_ADDR   8'hA2
`define EMB_AUX_CTRL_ADDR  8'h8E
`define EMB_P2_LATCH_ADDR  8'hA0
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define EMB_PTR_SEL_BIT    0
`define EMB_USER_FLAG_BIT  3
`define EMB_ALE_OFF_BIT    0
`define EMB_DBL_SPEED_BIT  1
`define EMB_P2_LATCH_RST   8'hFF
`define EMB_INT_TOP_RST    16'h3FFF
// ----------------------------------------
// Machine cycle timing
// ----------------------------------------
`define EMB_LAST_PHASE     3'd5
`define EMB_HALF_PHASE     3'd3
`define EMB_DATA_END_PHASE 3'd4
`endif

// ===== common/emb_pkg.sv
// Types shared by the external memory bus block.
// Assumes no other package.
package emb_pkg;
	typedef enum logic [1:0] {
		MC_FETCH = 2'b01,
		MC_DATA  = 2'b10
	} emb_mc_e;
endpackage

// ===== rtl/emb_ext_bus.sv
// External program and data memory bus with the dual data pointer.
// Assumes the core holds fetchAddr steady for each fetch half cycle,
// and that pins are sampled and driven on the single clock.
// Functional notes
// - Low address byte then data byte share the multiplexed port.
// - Port drives address and write data actively, floating for reads and internal fetches.
// - External fetches and pointer moves put high address on upper port.
// - Register-indirect moves keep upper port latch on upper port.
// - Address strobe at osc/6, or osc/3 in double speed.
// - Each data access omits exactly one address strobe pulse.
// - Control bit 0 set silences address strobe on internal fetches.
// - Program read strobe pulses twice per external machine cycle.
// - Data access suppresses two program read strobe pulses.
// - Program read strobe stays high on internal fetches.
// - Select input low: every fetch goes to external memory.
// - Select input high: external only above the internal limit.
// - Protection level 1 uses the select input latched on the first clock after reset.
// - Data writes use a dedicated active-low write strobe.
// - Data reads use a dedicated active-low read strobe.
// - Two independent 16-bit pointers can address data memory.
// - Select bit 0 picks the pointer; resets to first pointer.
// - Bit 3 is a plain user flag, reset 0.
// - Unimplemented select register bits read zero; writes ignored.
`timescale 1ns/1ns
`default_nettype none
`include "emb_defines.svh"
module emb_ext_bus #(
	parameter logic [15:0] INT_TOP = `EMB_INT_TOP_RST, // Internal limit
	parameter bit          HAS_ROM = 1'b1              // Internal code
) (
	input  wire logic        clock,            // Oscillator clock
	input  wire logic        rst,              // Synchronous reset
	input  wire logic [7:0]  regAddr,          // Register address
	input  wire logic [7:0]  regWData,         // Register write data
	input  wire logic        regWr,            // Register write strobe
	input  wire logic        regRd,            // Register read strobe
	output logic      [7:0]  regRData,         // Read data, next cycle
	input  wire logic [15:0] fetchAddr,        // Code fetch address
	output logic      [7:0]  fetchData,        // Fetched external byte
	output logic             fetchValid,       // Fetch byte pulse
	output logic             fetchExt,         // Fetch goes external
	input  wire logic        movxReq,          // Data move request
	input  wire logic        movxWrite,        // Move is a write
	input  wire logic        movxUseDptr,      // Move uses the pointer
	input  wire logic [7:0]  movxRiAddr,       // Indirect low address
	input  wire logic [7:0]  movxWData,        // Move write data
	output logic      [7:0]  movxRData,        // Move read data
	output logic             movxDone,         // Move finished pulse
	output logic             movxBusy,         // Move pending
	input  wire logic        dpLoadLo,         // Load pointer low byte
	input  wire logic        dpLoadHi,         // Load pointer high byte
	input  wire logic [7:0]  dpLoadData,       // Pointer load byte
	input  wire logic        dpInc,            // Increment pointer
	output logic      [15:0] dpValue,          // Selected pointer
	input  wire logic        extFetchSel_n,    // External access pin
	input  wire logic        codeProtL1,       // Protection level 1
	input  wire logic [7:0]  p0In,             // Low port pin input
	output logic      [7:0]  p0Out,            // Low port pin output
	output logic             p0Oe,             // Low port drive enable
	output logic      [7:0]  p2Out,            // Upper port pins
	output logic             ale,              // Address latch strobe
	output logic             progReadStrobe_n, // Program read strobe
	output logic             wrStrobe_n,       // Data write strobe
	output logic             rdStrobe_n        // Data read strobe
);
	if (INT_TOP == 16'hFFFF) begin : g_bad_top
		$error("INT_TOP leaves no external code space");
	end

	// ----------------------------------------
	// Registers and their decode
	// ----------------------------------------
	logic        ptrSel_ff;
	logic        userFlag_ff;
	logic        aleOff_ff;
	logic        dblSpeed_ff;
	logic [7:0]  p2Latch_ff;
	logic [7:0]  regRData_ff;
	logic [15:0] dp_ff [2];
	wire         selHit  = regAddr == `EMB_AUX_SEL_ADDR;
	wire         ctrlHit = regAddr == `EMB_AUX_CTRL_ADDR;
	wire         p2Hit   = regAddr == `EMB_P2_LATCH_ADDR;
	wire  [7:0]  selRead = {4'h0, userFlag_ff, 2'h0, ptrSel_ff};
	wire  [7:0]  ctrlRead = {6'h00, dblSpeed_ff, aleOff_ff};
	wire  [7:0]  nxt_regRData = selHit ? selRead :
		ctrlHit ? ctrlRead : p2Hit ? p2Latch_ff : 8'h00;

	always_ff @(posedge clock) begin
		if (rst) begin
			ptrSel_ff   <= 1'b0;
			userFlag_ff <= 1'b0;
		end else if (regWr && selHit) begin
			ptrSel_ff   <= regWData[`EMB_PTR_SEL_BIT];
			userFlag_ff <= regWData[`EMB_USER_FLAG_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			aleOff_ff   <= 1'b0;
			dblSpeed_ff <= 1'b0;
			p2Latch_ff  <= `EMB_P2_LATCH_RST;
		end else if (regWr) begin
			if (ctrlHit) begin
				aleOff_ff   <= regWData[`EMB_ALE_OFF_BIT];
				dblSpeed_ff <= regWData[`EMB_DBL_SPEED_BIT];
			end
			if (p2Hit)
				p2Latch_ff <= regWData;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			regRData_ff <= 8'h00;
		else if (regRd)
			regRData_ff <= nxt_regRData;
	end
	assign regRData = regRData_ff;

	// ----------------------------------------
	// Dual data pointer
	// ----------------------------------------
	// per-pointer update
	for (genvar i = 0; i < 2; i++) begin : g_dp
		wire mine = ptrSel_ff == 1'(i);
		always_ff @(posedge clock) begin
			if (rst)
				dp_ff[i] <= 16'h0000;
			else if (mine && dpLoadLo)
				dp_ff[i][7:0] <= dpLoadData;
			else if (mine && dpLoadHi)
				dp_ff[i][15:8] <= dpLoadData;
			else if (mine && dpInc)
				dp_ff[i] <= dp_ff[i] + 16'h0001;
		end
	end
	assign dpValue = dp_ff[ptrSel_ff];

	// ----------------------------------------
	// External access select capture
	// ----------------------------------------
	logic eaCap_ff;
	logic eaDone_ff;
	always_ff @(posedge clock) begin
		if (rst) begin
			eaCap_ff  <= 1'b0;
			eaDone_ff <= 1'b0;
		end else if (!eaDone_ff) begin
			eaCap_ff  <= extFetchSel_n;
			eaDone_ff <= 1'b1;
		end
	end
	wire eaHigh = codeProtL1 ? eaCap_ff : extFetchSel_n;
	assign fetchExt = !HAS_ROM || !eaHigh || (fetchAddr > INT_TOP);

	// ----------------------------------------
	// Phase sequencer
	// ----------------------------------------
	logic           div_ff;
	logic [2:0]     phase_ff;
	emb_pkg::emb_mc_e mc_ff;
	// phase tick every 2 clocks, or every clock in double speed
	wire tick     = dblSpeed_ff || div_ff;
	wire cycEnd   = tick && phase_ff == `EMB_LAST_PHASE;
	wire isData   = mc_ff == emb_pkg::MC_DATA;
	wire addrPh   = phase_ff == 3'd0 || phase_ff == `EMB_HALF_PHASE;
	wire [2:0] nxt_phase = cycEnd ? 3'd0 : phase_ff + 3'd1;

	always_ff @(posedge clock) begin
		if (rst) begin
			div_ff   <= 1'b0;
			phase_ff <= 3'd0;
		end else begin
			div_ff <= !dblSpeed_ff && !div_ff;
			if (tick)
				phase_ff <= nxt_phase;
		end
	end

	// ----------------------------------------
	// Data move request
	// ----------------------------------------
	logic        pend_ff;
	logic        curWrite_ff;
	logic        curDptr_ff;
	logic [15:0] curAddr_ff;
	logic [7:0]  curWData_ff;
	wire  [15:0] nxt_curAddr = movxUseDptr ? dpValue :
		{p2Latch_ff, movxRiAddr};
	assign movxBusy = pend_ff;

	always_ff @(posedge clock) begin
		if (rst)
			pend_ff <= 1'b0;
		else if (movxReq && !pend_ff)
			pend_ff <= 1'b1;
		else if (cycEnd && isData)
			pend_ff <= 1'b0;
	end

	always_ff @(posedge clock) begin
		if (movxReq && !pend_ff) begin
			curWrite_ff <= movxWrite;
			curDptr_ff  <= movxUseDptr;
			curAddr_ff  <= nxt_curAddr;
			curWData_ff <= movxWData;
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			mc_ff <= emb_pkg::MC_FETCH;
		else if (cycEnd)
			mc_ff <= (pend_ff && !isData) ? emb_pkg::MC_DATA
				: emb_pkg::MC_FETCH;
	end

	// ----------------------------------------
	// Pin values
	// ----------------------------------------
	wire strobePh = phase_ff != 3'd0 && phase_ff != `EMB_LAST_PHASE;
	// data cycle keeps only its first strobe
	wire nxt_ale = isData ? phase_ff == 3'd0 :
		addrPh && (fetchExt || !aleOff_ff);
	// program read in the data phases of each half
	wire nxt_program_read_strobe_n = isData || !fetchExt || addrPh;
	wire nxt_wr_n = !(isData && curWrite_ff && strobePh);
	wire nxt_rd_n = !(isData && !curWrite_ff && strobePh);
	// address first, then write data, driven actively
	wire nxt_p0Oe = isData ? (phase_ff == 3'd0 || curWrite_ff) :
		addrPh && fetchExt;
	wire [7:0] nxt_p0Out = isData ?
		(phase_ff == 3'd0 ? curAddr_ff[7:0] : curWData_ff) :
		fetchAddr[7:0];
	wire [7:0] nxt_p2Out = isData ?
		(curDptr_ff ? curAddr_ff[15:8] : p2Latch_ff) :
		(fetchExt ? fetchAddr[15:8] : p2Latch_ff);

	always_ff @(posedge clock) begin
		if (rst) begin
			ale              <= 1'b0;
			progReadStrobe_n <= 1'b1;
			wrStrobe_n       <= 1'b1;
			rdStrobe_n       <= 1'b1;
			p0Oe             <= 1'b0;
			p0Out            <= 8'h00;
			p2Out            <= `EMB_P2_LATCH_RST;
		end else begin
			ale              <= nxt_ale;
			progReadStrobe_n <= nxt_program_read_strobe_n;
			wrStrobe_n       <= nxt_wr_n;
			rdStrobe_n       <= nxt_rd_n;
			p0Oe             <= nxt_p0Oe;
			p0Out            <= nxt_p0Out;
			p2Out            <= nxt_p2Out;
		end
	end

	// ----------------------------------------
	// Captured data and completion pulses
	// ----------------------------------------
	wire fetchTake = tick && !isData && !addrPh &&
		(phase_ff == 3'd2 || phase_ff == `EMB_LAST_PHASE);
	wire readTake = tick && isData && !curWrite_ff &&
		phase_ff == `EMB_DATA_END_PHASE;

	always_ff @(posedge clock) begin
		if (rst) begin
			fetchData  <= 8'h00;
			fetchValid <= 1'b0;
			movxRData  <= 8'h00;
			movxDone   <= 1'b0;
		end else begin
			fetchValid <= fetchTake;
			movxDone   <= cycEnd && isData;
			if (fetchTake && fetchExt)
				fetchData <= p0In;
			if (readTake)
				movxRData <= p0In;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_ale_norm;
		ale ##1 ale ##1 !ale;
	endsequence

	a_ale_width: assert property ($rose(ale) && !$past(dblSpeed_ff)
		&& !$past(dblSpeed_ff, 2) && $past(phase_ff) != $past(phase_ff, 2)
		&& (isData || fetchExt) |-> s_ale_norm)
		else $error("address strobe width wrong in normal mode");
	a_ale_skip: assert property (isData
		&& phase_ff >= `EMB_HALF_PHASE |=> !ale)
		else $error("address strobe not skipped in data cycle");
	a_ale_quiet: assert property (!isData && !fetchExt && aleOff_ff
		|=> !ale)
		else $error("address strobe active on internal fetch");
	a_program_read_strobe_pulse: assert property (!isData && fetchExt && tick
		&& phase_ff == 3'd0 ##1 fetchExt |=> !progReadStrobe_n)
		else $error("program read strobe missing");
	a_program_read_strobe_data: assert property (isData |=> progReadStrobe_n)
		else $error("program read strobe during data access");
	a_program_read_strobe_int: assert property (!fetchExt && !isData
		|=> progReadStrobe_n)
		else $error("program read strobe on internal fetch");
	a_p2_ptr: assert property (isData && curDptr_ff
		|=> p2Out == $past(curAddr_ff[15:8]))
		else $error("upper port lacks pointer high byte");
	a_p2_latch: assert property (isData && !curDptr_ff
		|=> p2Out == $past(p2Latch_ff))
		else $error("upper port not showing its latch");
	a_wr_cause: assert property (!wrStrobe_n
		|-> $past(isData && curWrite_ff))
		else $error("write strobe outside a data write");
	a_rd_cause: assert property (!rdStrobe_n
		|-> $past(isData && !curWrite_ff))
		else $error("read strobe outside a data read");
	a_dp_hold: assert property (!ptrSel_ff && (dpInc || dpLoadLo)
		|=> $stable(dp_ff[1]))
		else $error("unselected pointer changed");
	a_ea_latch: assert property (eaDone_ff |=> $stable(eaCap_ff))
		else $error("latched access select changed");
endmodule // emb_ext_bus
`default_nettype wire

// ===== verification/emb_mem_model.sv
// Behavioural external code and data memory for the bus block.
// Assumes registered pins from the block and one shared clock.
`timescale 1ns/1ns
`default_nettype none
module emb_mem_model (
	input  wire logic        clock,            // Oscillator clock
	input  wire logic        ale,              // Address latch strobe
	input  wire logic        progReadStrobe_n, // Code read strobe
	input  wire logic        rdStrobe_n,       // Data read strobe
	input  wire logic        wrStrobe_n,       // Data write strobe
	input  wire logic        p0Oe,             // Low port drive enable
	input  wire logic [7:0]  p0Out,            // Low port output
	input  wire logic [7:0]  p2Out,            // Upper port
	output logic      [7:0]  p0In,             // Resolved low port level
	output logic      [15:0] wrAddr,           // Last write address
	output logic      [7:0]  wrData            // Last write byte
);
	logic [15:0] addrLatch;
	logic [7:0]  lastLvl;
	logic [7:0]  mem [0:255];
	wire  [7:0]  codeByte = addrLatch[15:8] ^ addrLatch[7:0] ^ 8'h5A;
	// port level.
	// An undriven port shows the inverse of its last level, never a copy.
	always_comb begin
		if (p0Oe)
			p0In = p0Out;
		else if (!progReadStrobe_n)
			p0In = codeByte;
		else if (!rdStrobe_n)
			p0In = mem[addrLatch[7:0]];
		else
			p0In = ~lastLvl;
	end
	always @(posedge clock) begin
		lastLvl <= p0In;
		if (ale)
			addrLatch <= {p2Out, p0In};
		if (!wrStrobe_n) begin
			mem[addrLatch[7:0]] <= p0In;
			wrAddr <= addrLatch;
			wrData <= p0In;
		end
	end
endmodule // emb_mem_model
`default_nettype wire

// ===== verification/tb.sv
// Self-checking bench for the external memory bus block.
// Assumes the block, its defines and the memory model compile first.
`timescale 1ns/1ns
`default_nettype none
`include "emb_defines.svh"
module tb;
	logic        clock = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0;
	logic [7:0]  regAddr = 8'h00, regWData = 8'h00, regRData, rv;
	logic [15:0] fetchAddr = 16'h1234, dpValue, wrAddr;
	logic [7:0]  movxRiAddr = 8'h00, movxWData = 8'h00, dpLoadData = 8'h00;
	logic [7:0]  fetchData, movxRData, p0In, p0Out, p2Out, wrData;
	logic [7:0]  rdVal, fvData;
	logic        movxReq = 1'b0, movxWrite = 1'b0, movxUseDptr = 1'b0;
	logic        dpLoadLo = 1'b0, dpLoadHi = 1'b0, dpInc = 1'b0;
	logic        extFetchSel_n = 1'b0, codeProtL1 = 1'b0;
	logic        fetchValid, fetchExt, movxDone, movxBusy, p0Oe, ale;
	logic        progReadStrobe_n, wrStrobe_n, rdStrobe_n;
	logic        aleQ, psenQ, wrQ, rdQ;
	int          badCount = 0, testsRun = 0;
	int          aleCnt, psenCnt, wrCnt, rdCnt, doneCnt, fvCnt;
	emb_ext_bus i_emb_ext_bus (
		.clock, .rst, .regAddr, .regWData, .regWr, .regRd, .regRData,
		.fetchAddr, .fetchData, .fetchValid, .fetchExt, .movxReq,
		.movxWrite, .movxUseDptr, .movxRiAddr, .movxWData, .movxRData,
		.movxDone, .movxBusy, .dpLoadLo, .dpLoadHi, .dpLoadData, .dpInc,
		.dpValue, .extFetchSel_n, .codeProtL1, .p0In, .p0Out, .p0Oe,
		.p2Out, .ale, .progReadStrobe_n, .wrStrobe_n, .rdStrobe_n
	);
	emb_mem_model i_emb_mem_model (
		.clock, .ale, .progReadStrobe_n, .rdStrobe_n, .wrStrobe_n, .p0Oe,
		.p0Out, .p2Out, .p0In, .wrAddr, .wrData
	);
	always #5 clock = ~clock;
	// Edge counts are taken at the falling edge, clear of any race.
	always @(negedge clock) begin
		aleCnt += int'(ale && !aleQ);
		psenCnt += int'(!progReadStrobe_n && psenQ);
		wrCnt += int'(!wrStrobe_n && wrQ);
		rdCnt += int'(!rdStrobe_n && rdQ);
		doneCnt += int'(movxDone);
		fvCnt += int'(fetchValid);
		if (fetchValid)
			fvData <= fetchData;
		if (movxDone)
			rdVal <= movxRData;
		aleQ <= ale;
		psenQ <= progReadStrobe_n;
		wrQ <= wrStrobe_n;
		rdQ <= rdStrobe_n;
	end
	task automatic check(input string what, input logic [31:0] seen, exp);
		testsRun++;
		if (seen !== exp) begin
			badCount++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stopTest;
		$display("checks %0d mismatches %0d", testsRun, badCount);
		if (badCount == 0 && testsRun > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	task automatic clearCnt;
		{aleCnt, psenCnt, wrCnt, rdCnt, doneCnt, fvCnt} = '0;
	endtask
	task automatic window(input int n);
		tick(12);
		clearCnt();
		tick(n);
	endtask
	task automatic regWrite(input logic [7:0] a, d);
		regAddr <= a;
		regWData <= d;
		regWr <= 1'b1;
		tick(1);
		regWr <= 1'b0;
		tick(1);
	endtask
	task automatic regRead(input logic [7:0] a);
		regAddr <= a;
		regRd <= 1'b1;
		tick(1);
		regRd <= 1'b0;
		tick(1);
		rv = regRData;
	endtask
	task automatic loadDp(input logic [15:0] v);
		dpLoadData <= v[7:0];
		dpLoadLo <= 1'b1;
		tick(1);
		dpLoadLo <= 1'b0;
		dpLoadData <= v[15:8];
		dpLoadHi <= 1'b1;
		tick(1);
		dpLoadHi <= 1'b0;
		tick(1);
	endtask
	task automatic external_move_instruction(input logic w, dp, input logic [7:0] ri, wd);
		movxWrite <= w;
		movxUseDptr <= dp;
		movxRiAddr <= ri;
		movxWData <= wd;
		movxReq <= 1'b1;
		clearCnt();
		tick(1);
		movxReq <= 1'b0;
		tick(1);
		check("move busy", movxBusy, 1'b1);
		tick(46);
		check("move done", doneCnt, 1);
		check("move idle", movxBusy, 1'b0);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic testRegs;
		check("pointer reset", dpValue, 16'h0000);
		regRead(`EMB_AUX_SEL_ADDR);
		check("select reset", rv, 8'h00);
		regWrite(`EMB_AUX_SEL_ADDR, 8'h09);
		regRead(`EMB_AUX_SEL_ADDR);
		check("select bits", rv, 8'h09);
		regRead(8'h55);
		check("unmapped read", rv, 8'h00);
		regWrite(`EMB_AUX_SEL_ADDR, 8'h00);
		regRead(`EMB_AUX_SEL_ADDR);
		check("flag cleared", rv, 8'h00);
		$display("register test done");
	endtask
	task automatic testFetch;
		window(48);
		check("ale rate", aleCnt, 8);
		check("code strobes", psenCnt, 8);
		check("code bytes", fvCnt, 8);
		check("code byte", fvData, 8'h12 ^ 8'h34 ^ 8'h5A);
		check("external fetch", fetchExt, 1'b1);
		extFetchSel_n <= 1'b1;
		window(48);
		check("internal fetch", fetchExt, 1'b0);
		check("no code strobe", psenCnt, 0);
		check("ale kept", aleCnt, 8);
		regWrite(`EMB_AUX_CTRL_ADDR, 8'h01);
		window(48);
		check("ale silenced", aleCnt, 0);
		fetchAddr <= 16'h4000;
		window(48);
		check("above limit", fetchExt, 1'b1);
		check("ale external", aleCnt, 8);
		regWrite(`EMB_AUX_CTRL_ADDR, 8'h02);
		window(24);
		check("double ale", aleCnt, 8);
		check("double strobes", psenCnt, 8);
		regWrite(`EMB_AUX_CTRL_ADDR, 8'h00);
		extFetchSel_n <= 1'b0;
		fetchAddr <= 16'h1234;
		tick(1);
		$display("fetch test done");
	endtask
	task automatic testMoves;
		loadDp(16'h2345);
		regWrite(`EMB_AUX_SEL_ADDR, 8'h01);
		loadDp(16'h6789);
		check("second pointer", dpValue, 16'h6789);
		dpInc <= 1'b1;
		tick(1);
		dpInc <= 1'b0;
		tick(1);
		check("increment", dpValue, 16'h678A);
		external_move_instruction(1'b1, 1'b1, 8'h00, 8'hC3);
		check("write address", wrAddr, 16'h678A);
		check("write byte", wrData, 8'hC3);
		check("ale skip", aleCnt, 7);
		check("code skip", psenCnt, 6);
		check("write strobe", wrCnt, 1);
		regWrite(`EMB_AUX_SEL_ADDR, 8'h00);
		check("first kept", dpValue, 16'h2345);
		regWrite(`EMB_P2_LATCH_ADDR, 8'h5B);
		external_move_instruction(1'b1, 1'b0, 8'h77, 8'hA6);
		check("indirect address", wrAddr, 16'h5B77);
		external_move_instruction(1'b0, 1'b0, 8'h77, 8'h00);
		check("read byte", rdVal, 8'hA6);
		check("read strobe", rdCnt, 1);
		check("no write", wrCnt, 0);
		$display("move test done");
	endtask
	task automatic testProtect;
		codeProtL1 <= 1'b1;
		rst <= 1'b1;
		tick(3);
		rst <= 1'b0;
		tick(2);
		extFetchSel_n <= 1'b1;
		fetchAddr <= 16'h0100;
		tick(2);
		check("latched select", fetchExt, 1'b1);
		codeProtL1 <= 1'b0;
		tick(2);
		check("live select", fetchExt, 1'b0);
		$display("protection test done");
	endtask
	initial begin
		tick(3);
		rst <= 1'b0;
		tick(1);
		testRegs();
		testFetch();
		testMoves();
		testProtect();
		stopTest();
	end
endmodule // tb
`default_nettype wire
